// >>> hw/chgi2c_slave.sv
// Purpose: Two-wire slave port with five 8-bit registers and update stream
// Assumes: Serial clock and data arrive asynchronously and are double-synced
// Notes:   Data pin is open drain; only the enable is ever toggled
//          Update words leave through a two-entry buffer
//          Read pointer holds; it does not advance after a read byte
`timescale 1ns/1ps

module chgi2c_slave (
  // System
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Serial link
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Charger side
  input  wire logic [7:0] status_value,
  output logic            hs_mode,
  output logic            upd_valid,
  output logic [2:0]      upd_index,
  output logic [7:0]      upd_data,
  input  wire logic       upd_ready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    // Pin synchronisers and previous samples
    logic                   scl_m;
    logic                   scl_s;
    logic                   scl_p;
    logic                   sda_m;
    logic                   sda_s;
    logic                   sda_p;

    // Byte engine
    chgi2c_pkg::chgi2c_state_t state;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic [7:0]             tx;
    logic [7:0]             ptr;
    logic                   rw;
    logic                   nack;
    logic                   hs;
    logic                   oe;
    logic                   drv;

    // Writable registers
    logic [3:0][7:0]        rf;

    // Update buffer: head and second entry
    logic                   ov;
    logic [2:0]             oi;
    logic [7:0]             od;
    logic                   sv;
    logic [2:0]             si;
    logic [7:0]             sd;
  } chgi2c_st_t;

  chgi2c_st_t st_reg;
  chgi2c_st_t st_next;

  // Link conditions
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  // Update buffer control
  logic buf_full;
  logic pop;
  logic push;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Seven-bit compare; the direction bit is left out
  function automatic logic is_own_addr(input logic [7:0] b);
    return b[7:1] == chgi2c_pkg::CHGI2C_DEV_ADDR;
  endfunction

  function automatic logic is_hs_code(input logic [7:0] b);
    return b[7:3] == chgi2c_pkg::CHGI2C_HS_CODE;
  endfunction

  // Full 8-bit compare: index 4 reads status, any other nonzero upper bits fall to the unmapped value
  function automatic logic is_writable(input logic [7:0] idx);
    return idx < chgi2c_pkg::CHGI2C_RO_INDEX;
  endfunction

  // Eight data bits counted before the acknowledge slot
  function automatic logic is_byte_end(input logic [3:0] n);
    return n == chgi2c_pkg::CHGI2C_BYTE_BITS;
  endfunction

  // Most significant bit arrives first
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d);
    return {b[6:0], d};
  endfunction

  // Idle-high fill keeps the line released once the byte is out
  function automatic logic [7:0] shift_out(input logic [7:0] b);
    return {b[6:0], 1'b1};
  endfunction

  // Open drain: a zero bit is sent by enabling the pull-down
  function automatic logic drive_for(input logic b);
    return ~b;
  endfunction

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  function automatic logic [7:0] rd_value(input chgi2c_st_t s, input logic [7:0] stat, input logic [7:0] idx);
    logic [7:0] v;
    v = chgi2c_pkg::CHGI2C_UNMAPPED;
    // Unmapped unless a register is found below
    if (is_writable(idx)) begin
      v = s.rf[idx[1:0]];
    end else if (idx == chgi2c_pkg::CHGI2C_RO_INDEX) begin
      v = stat;
    end
    return v;
  endfunction

  // ----------------------------------------
  // Link conditions
  // ----------------------------------------
  // Edges seen only on synced copies; no filtering by design
  // Start and stop need the clock high on both samples
  assign scl_rise   = st_reg.scl_s & ~st_reg.scl_p;
  assign scl_fall   = ~st_reg.scl_s & st_reg.scl_p;
  assign start_seen = st_reg.scl_s & st_reg.scl_p & st_reg.sda_p & ~st_reg.sda_s;
  assign stop_seen  = st_reg.scl_s & st_reg.scl_p & ~st_reg.sda_p & st_reg.sda_s;
  assign buf_full   = st_reg.ov & st_reg.sv;
  assign pop        = st_reg.ov & upd_ready;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    push    = 1'b0;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    st_next.scl_m = scl_in;
    st_next.scl_s = st_reg.scl_m;
    st_next.scl_p = st_reg.scl_s;
    st_next.sda_m = sda_in;
    st_next.sda_s = st_reg.sda_m;
    st_next.sda_p = st_reg.sda_s;
    st_next.drv   = 1'b0;

    // ----------------------------------------
    // Bus conditions and byte engine
    // ----------------------------------------
    // Stop wins over any byte in progress; it also ends an abandoned frame
    if (stop_seen) begin
      st_next.state = chgi2c_pkg::CHGI2C_IDLE;
      st_next.oe    = 1'b0;
      st_next.hs    = 1'b0;
    end else if (start_seen) begin
      // Repeated start keeps the high-speed setting
      st_next.state = chgi2c_pkg::CHGI2C_ADDR;
      st_next.cnt   = 4'h0;
      st_next.oe    = 1'b0;
    end else begin
      unique case (st_reg.state)
        // Ignore everything until the next start or stop
        chgi2c_pkg::CHGI2C_IDLE, chgi2c_pkg::CHGI2C_WAIT: begin
          st_next.oe = 1'b0;
        end

        // Address, index and data bytes share one shifter
        chgi2c_pkg::CHGI2C_ADDR, chgi2c_pkg::CHGI2C_INDEX, chgi2c_pkg::CHGI2C_WDATA: begin
          if (scl_rise) begin
            st_next.sh  = shift_in(st_reg.sh, st_reg.sda_s);
            st_next.cnt = st_reg.cnt + 4'h1;
          end else if (scl_fall && is_byte_end(st_reg.cnt)) begin
            st_next.cnt = 4'h0;
            if (st_reg.state == chgi2c_pkg::CHGI2C_ADDR) begin
              if (is_own_addr(st_reg.sh)) begin
                st_next.oe    = 1'b1;
                st_next.rw    = st_reg.sh[0];
                st_next.state = chgi2c_pkg::CHGI2C_ACK_ADDR;
              end else begin
                if (is_hs_code(st_reg.sh)) begin
                  st_next.hs = 1'b1;
                end
                st_next.state = chgi2c_pkg::CHGI2C_WAIT;
              end

            end else if (st_reg.state == chgi2c_pkg::CHGI2C_INDEX) begin
              st_next.ptr   = st_reg.sh;
              st_next.oe    = 1'b1;
              st_next.state = chgi2c_pkg::CHGI2C_ACK_INDEX;
            end else if (!buf_full) begin
              st_next.oe    = 1'b1;
              st_next.state = chgi2c_pkg::CHGI2C_ACK_DATA;
            end else begin
              // No room downstream: refuse the byte rather than lose it
              st_next.state = chgi2c_pkg::CHGI2C_WAIT;
            end
          end
        end

        // Acknowledge stands through the ninth clock; read data starts at its fall
        chgi2c_pkg::CHGI2C_ACK_ADDR: begin
          if (scl_fall) begin
            if (st_reg.rw) begin
              st_next.tx    = rd_value(st_reg, status_value, st_reg.ptr);
              st_next.oe    = drive_for(st_next.tx[7]);
              st_next.state = chgi2c_pkg::CHGI2C_RDATA;
            end else begin
              st_next.oe    = 1'b0;
              st_next.state = chgi2c_pkg::CHGI2C_INDEX;
            end
          end
        end

        // Index acknowledged; the data byte follows
        chgi2c_pkg::CHGI2C_ACK_INDEX: begin
          if (scl_fall) begin
            st_next.oe    = 1'b0;
            st_next.state = chgi2c_pkg::CHGI2C_WDATA;
          end
        end

        chgi2c_pkg::CHGI2C_ACK_DATA: begin
          if (scl_fall) begin
            st_next.oe = 1'b0;
            // Index 4 and up is acknowledged but neither stored nor pushed
            if (is_writable(st_reg.ptr)) begin
              st_next.rf[st_reg.ptr[1:0]] = st_reg.sh;
              push = 1'b1;
            end
            st_next.state = chgi2c_pkg::CHGI2C_INDEX;
          end
        end

        // Eight bits out, then the master's acknowledge slot
        chgi2c_pkg::CHGI2C_RDATA: begin
          if (scl_rise) begin
            st_next.cnt = st_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (is_byte_end(st_reg.cnt)) begin
              st_next.oe    = 1'b0;
              st_next.cnt   = 4'h0;
              st_next.state = chgi2c_pkg::CHGI2C_RACK;
            end else begin
              // Next bit is put out while the clock is low
              st_next.tx = shift_out(st_reg.tx);
              st_next.oe = drive_for(st_reg.tx[6]);
            end
          end
        end

        // Master nack ends the read; the pointer stays for the next read
        chgi2c_pkg::CHGI2C_RACK: begin
          if (scl_rise) begin
            st_next.nack = st_reg.sda_s;
          end else if (scl_fall) begin
            if (st_reg.nack) begin
              st_next.state = chgi2c_pkg::CHGI2C_WAIT;
            end else begin
              st_next.tx    = rd_value(st_reg, status_value, st_reg.ptr);
              st_next.oe    = drive_for(st_next.tx[7]);
              st_next.state = chgi2c_pkg::CHGI2C_RDATA;
            end
          end
        end

        default: begin
          st_next.state = chgi2c_pkg::CHGI2C_IDLE;
        end
      endcase
    end

    // ----------------------------------------
    // Update buffer
    // ----------------------------------------
    // Head drives the ports; the second entry catches one stall
    // A full buffer makes the data byte go unacknowledged upstream
    // Pop first so a push in the same cycle sees the freed head
    if (pop) begin
      st_next.ov = st_reg.sv;
      st_next.oi = st_reg.si;
      st_next.od = st_reg.sd;
      st_next.sv = 1'b0;
    end
    if (push) begin
      if (!st_next.ov) begin
        st_next.ov = 1'b1;
        st_next.oi = st_reg.ptr[2:0];
        st_next.od = st_reg.sh;
      end else begin
        st_next.sv = 1'b1;
        st_next.si = st_reg.ptr[2:0];
        st_next.sd = st_reg.sh;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg       <= '0;
      // Outputs named again so their reset levels read at a glance
      st_reg.oe    <= 1'b0;
      st_reg.drv   <= 1'b0;
      st_reg.hs    <= 1'b0;
      st_reg.ov    <= 1'b0;
      st_reg.sv    <= 1'b0;
      // Synchronisers start at the idle level so no false edge follows reset
      st_reg.scl_m <= 1'b1;
      st_reg.scl_s <= 1'b1;
      st_reg.scl_p <= 1'b1;
      st_reg.sda_m <= 1'b1;
      st_reg.sda_s <= 1'b1;
      st_reg.sda_p <= 1'b1;
      st_reg.state <= chgi2c_pkg::CHGI2C_IDLE;
      st_reg.rf    <= {4{chgi2c_pkg::CHGI2C_RF_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pin value is always low; only the enable toggles
  assign sda_out   = st_reg.drv;
  assign sda_oe    = st_reg.oe;
  assign hs_mode   = st_reg.hs;
  assign upd_valid = st_reg.ov;
  assign upd_index = st_reg.oi;
  assign upd_data  = st_reg.od;

endmodule

// >>> inc/chgi2c_pkg.sv
// Purpose: Constants and types for the charger two-wire slave port
// Assumes: Link pins sampled by the 50 MHz system clock

package chgi2c_pkg;

  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [6:0] CHGI2C_DEV_ADDR  = 7'h6b;
  localparam logic [4:0] CHGI2C_HS_CODE   = 5'h01;
  localparam logic [7:0] CHGI2C_RO_INDEX  = 8'h04;
  localparam logic [7:0] CHGI2C_UNMAPPED  = 8'hff;
  localparam logic [7:0] CHGI2C_RF_RESET  = 8'h00;
  localparam logic [3:0] CHGI2C_BYTE_BITS = 4'h8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    CHGI2C_IDLE,
    CHGI2C_ADDR,
    CHGI2C_ACK_ADDR,
    CHGI2C_INDEX,
    CHGI2C_ACK_INDEX,
    CHGI2C_WDATA,
    CHGI2C_ACK_DATA,
    CHGI2C_RDATA,
    CHGI2C_RACK,
    CHGI2C_WAIT
  } chgi2c_state_t;

endpackage

// >>> tb/chgi2c_master_bfm.sv
// Purpose: Two-wire bus master model, 160 ns bit period
// Assumes: Data wire resolved outside with a pull-up
// Notes:   Clock stands high between frames
`timescale 1ns/1ps

module chgi2c_master_bfm (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      m_oe
);
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Data moves mid low phase only
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    q(2);
    m_oe = !b;
    q(4);
    scl = 1'b1;
    q(1);
    r = sda;
    q(1);
  endtask
  // Start or repeated start
  task automatic start();
    logic r;
    // A slave still holding its acknowledge needs one more low phase first
    if (scl == 1'b0 || m_oe || sda == 1'b0) bit_x(1'b1, r);
    m_oe = 1'b1;
    q(2);
  endtask
  // Stop, then bus free time
  task automatic stop();
    logic r;
    bit_x(1'b0, r);
    m_oe = 1'b0;
    q(12);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // Master acknowledges as receiver
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(!mack, r);
  endtask
endmodule

// >>> tb/chgi2c_slave_chk.sv
// Purpose: Port assertions for the charger slave port
// Assumes: Master moves data only in the clock low phase
// Notes:   Bound onto every chgi2c_slave
`timescale 1ns/1ps

module chgi2c_slave_chk (
  // System
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // Link
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Charger side
  input wire logic [7:0] status_value,
  input wire logic       hs_mode,
  input wire logic       upd_valid,
  input wire logic [2:0] upd_index,
  input wire logic [7:0] upd_data,
  input wire logic       upd_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  a_drive_low: assert property (sda_out == 1'b0) else $error("data pin driven high");
  a_oe_hold: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("oe moved in high");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("oe rose in high");
  a_stop_free: assert property (s_stop |=> !sda_oe [*8]) else $error("bus held after stop");
  a_stop_hs: assert property (s_stop |-> ##[1:6] !hs_mode) else $error("hs kept after stop");
  a_upd_hold: assert property (upd_valid && !upd_ready |=> upd_valid && $stable({upd_index, upd_data}))
    else $error("update word lost");
  a_upd_index: assert property (upd_valid |-> upd_index <= 3'h3) else $error("index out of range");
  a_push_low: assert property ($rose(upd_valid) |-> !scl_in) else $error("push in clock high");
  a_rst_quiet: assert property (disable iff (1'b0) !arst_n |-> !sda_oe && !upd_valid && !hs_mode)
    else $error("outputs active in reset");
  c_take: cover property (upd_valid && upd_ready);
  c_hs: cover property ($rose(hs_mode));
  c_stall: cover property (upd_valid && !upd_ready ##1 upd_valid);
endmodule

bind chgi2c_slave chgi2c_slave_chk u_chgi2c_slave_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .status_value(status_value), .hs_mode(hs_mode),
  .upd_valid(upd_valid), .upd_index(upd_index), .upd_data(upd_data), .upd_ready(upd_ready)
);

// >>> tb/chgi2c_slave_test.sv
// Purpose: Self-checking bench of the charger slave port
// Assumes: Master model on the link, bench as consumer
// Notes:   Read pointer is not incremented
`timescale 1ns/1ps

module chgi2c_slave_test;
  logic       sys_clk = 1'b0;
  logic       arst_n;
  logic       upd_ready = 1'b0;
  logic [7:0] status_value = 8'hc3;
  logic       sda_out, sda_oe, hs_mode, upd_valid, scl, m_oe, sda, a;
  logic [2:0] upd_index;
  logic [7:0] upd_data, d;
  logic [10:0] got_q[$];
  int         fails = 0;
  int         cmp_count = 0;
  assign sda = !(m_oe || sda_oe);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (upd_valid === 1'b1 && upd_ready === 1'b1) got_q.push_back({upd_index, upd_data});
  chgi2c_slave u_chgi2c_slave (.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .status_value(status_value), .hs_mode(hs_mode),
    .upd_valid(upd_valid), .upd_index(upd_index), .upd_data(upd_data), .upd_ready(upd_ready));
  chgi2c_master_bfm u_chgi2c_master_bfm (.sys_clk(sys_clk), .sda(sda), .scl(scl), .m_oe(m_oe));
  // ----------------------------------------
  // Compare and closing tasks
  // ----------------------------------------
  task automatic chk_bit(input logic g, input logic e, input string w);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s: got %b", $time, w, g);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t read %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [10:0] e);
    logic [10:0] g;
    g = 11'h7ff;
    if (got_q.size() > 0) g = got_q.pop_front();
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write();
    upd_ready = 1'b1;
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'hd6, a);
    chk_bit(a, 1'b1, "addr ack");
    u_chgi2c_master_bfm.wbyte(8'h02, a);
    chk_bit(a, 1'b1, "index ack");
    u_chgi2c_master_bfm.wbyte(8'h5a, a);
    chk_bit(a, 1'b1, "data ack");
    u_chgi2c_master_bfm.wbyte(8'h00, a);
    u_chgi2c_master_bfm.wbyte(8'ha5, a);
    chk_bit(a, 1'b1, "second data ack");
    u_chgi2c_master_bfm.wbyte(8'h04, a);
    u_chgi2c_master_bfm.wbyte(8'h99, a);
    chk_bit(a, 1'b1, "read-only data ack");
    u_chgi2c_master_bfm.stop();
    chk_word({3'h2, 8'h5a});
    chk_word({3'h0, 8'ha5});
    chk_bit(got_q.size() == 0, 1'b1, "read-only not pushed");
    $display("t_write done");
  endtask
  task automatic t_badaddr();
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'hd4, a);
    chk_bit(a, 1'b0, "foreign addr");
    u_chgi2c_master_bfm.wbyte(8'h02, a);
    u_chgi2c_master_bfm.stop();
    chk_bit(a, 1'b0, "ignored byte");
    chk_bit(got_q.size() == 0, 1'b1, "no update");
    $display("t_badaddr done");
  endtask
  task automatic t_read(input logic [7:0] idx, input logic [7:0] e);
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'hd6, a);
    u_chgi2c_master_bfm.wbyte(idx, a);
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'hd7, a);
    chk_bit(a, 1'b1, "read addr ack");
    u_chgi2c_master_bfm.rbyte(1'b0, d);
    u_chgi2c_master_bfm.stop();
    chk_byte(d, e);
    $display("t_read %h done", idx);
  endtask
  task automatic t_hs();
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'h0a, a);
    chk_bit(a, 1'b0, "master code ack");
    chk_bit(hs_mode, 1'b1, "hs entry");
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'hd6, a);
    chk_bit(a, 1'b1, "hs addr ack");
    u_chgi2c_master_bfm.wbyte(8'h03, a);
    u_chgi2c_master_bfm.wbyte(8'h77, a);
    u_chgi2c_master_bfm.start();
    chk_bit(hs_mode, 1'b1, "hs kept");
    u_chgi2c_master_bfm.stop();
    chk_bit(hs_mode, 1'b0, "hs left");
    chk_word({3'h3, 8'h77});
    $display("t_hs done");
  endtask
  task automatic t_full();
    upd_ready = 1'b0;
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'hd6, a);
    for (int i = 0; i < 3; i++) begin
      u_chgi2c_master_bfm.wbyte(8'(i), a);
      u_chgi2c_master_bfm.wbyte(8'h11 * 8'(i), a);
      chk_bit(a, i < 2, "full buffer ack");
    end
    u_chgi2c_master_bfm.stop();
    chk_bit(upd_valid, 1'b1, "stalled head");
    upd_ready = 1'b1;
    u_chgi2c_master_bfm.q(6);
    chk_word({3'h0, 8'h00});
    chk_word({3'h1, 8'h11});
    chk_bit(upd_valid, 1'b0, "drained");
    $display("t_full done");
  endtask
  task automatic t_reset();
    upd_ready = 1'b0;
    u_chgi2c_master_bfm.start();
    u_chgi2c_master_bfm.wbyte(8'hd6, a);
    u_chgi2c_master_bfm.wbyte(8'h01, a);
    u_chgi2c_master_bfm.wbyte(8'h3c, a);
    u_chgi2c_master_bfm.start();
    chk_bit(upd_valid, 1'b1, "word before reset");
    arst_n = 1'b0;
    u_chgi2c_master_bfm.q(2);
    chk_bit(upd_valid, 1'b0, "reset clears head");
    chk_bit(sda_oe, 1'b0, "reset frees bus");
    arst_n = 1'b1;
    upd_ready = 1'b1;
    u_chgi2c_master_bfm.q(4);
    u_chgi2c_master_bfm.stop();
    chk_bit(got_q.size() == 0, 1'b1, "no word after reset");
    t_read(8'h01, 8'h00);
    $display("t_reset done");
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    arst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    u_chgi2c_master_bfm.q(4);
    t_write();
    t_badaddr();
    t_read(8'h02, 8'h5a);
    t_read(8'h04, 8'hc3);
    t_read(8'h07, 8'hff);
    t_hs();
    t_full();
    t_reset();
    wrap_up();
  end
endmodule
